// ==== shared/etc_pkg.sv ====
// Package for the 8-bit timer channel zero control block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package etc_pkg;
    // Printed offsets are not all multiples of four: kept as indices, byte address = 4 * index
    localparam logic [15:0] SER_TMR_CLK_CTRL_IDX = 16'hffc3;
    localparam logic [15:0] TIMER0_CONTROL_IDX = 16'hffc8;
    localparam logic [15:0] PERIPH_CLK_CTRL_IDX = 16'hffc2;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'hffe0;
    localparam logic [15:0] IRQ_CLEAR_IDX = 16'hffe1;
    localparam logic [15:0] IRQ_ENABLE_IDX = 16'hffe2;
    localparam logic [15:0] COMPARE_A_IDX = 16'hffe4;
    localparam logic [15:0] COMPARE_B_IDX = 16'hffe5;
    localparam logic [15:0] COUNTER_IDX = 16'hffe6;
    localparam int ADDR_W = 18;
    localparam int IDX_LSB = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] PRESCALE_RESET = 2'h0;
    localparam int PHALVE_BIT = 5;
    localparam int PRESCALE_SEL_BIT = 0;
    localparam int PRESCALE_W = 10;
    // Status / enable / clear layout
    localparam int EV_CMPB = 2;
    localparam int EV_CMPA = 1;
    localparam int EV_OVF = 0;
    localparam int EV_W = 3;
    // Clock select codes
    localparam logic [2:0] CKS_STOP0 = 3'h0;
    localparam logic [2:0] CKS_DIV_A = 3'h1;
    localparam logic [2:0] CKS_DIV_B = 3'h2;
    localparam logic [2:0] CKS_DIV_C = 3'h3;
    localparam logic [2:0] CKS_STOP4 = 3'h4;
    localparam logic [2:0] CKS_EXT_RISE = 3'h5;
    localparam logic [2:0] CKS_EXT_FALL = 3'h6;
    localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
    // Prescaler tap bits: divide by 2^(tap+1)
    localparam int TAP_DIV8 = 2;
    localparam int TAP_DIV64 = 5;
    localparam int TAP_DIV1024 = 9;
    localparam int TAP_DIV2 = 0;
    localparam int TAP_DIV32 = 4;
    localparam int TAP_DIV256 = 7;
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_CMPA = 2'h1;
    localparam logic [1:0] CLR_CMPB = 2'h2;
    localparam logic [1:0] CLR_EXT = 2'h3;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    typedef struct packed {
        logic cmpBIrqEn;
        logic cmpAIrqEn;
        logic overflowIrqEn;
        logic [1:0] clearSel;
        logic [2:0] clkSel;
    } etc_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } etc_apb_req_t;
endpackage

// ==== core/etc_timer0_control.sv ====
// 8-bit timer channel zero: control register, prescaler, counter and interrupts.
// Assumes an APB master on the same clock; ext pins are asynchronous.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Divide setting 1 runs the prescaler base at half the system clock.
// - Divide setting 0 runs the prescaler base at the system clock.
// - Clock select 000 or 100 stops the counter.
// - Selects 001-011 count prescaler falling edges, divisors by alternate bit.
// - Selects 101-111 count external rising, falling or both edges.
// - Clear field 00 never clears; 01 and 10 clear on match A or B.
// - Clear field 11 clears on each external reset rising edge.
// - Overflow interrupt passes only while its enable bit is one.
// - Compare A interrupt passes only while its enable bit is one.
// - Control layout: 7 B en, 6 A en, 5 ovf en, 4:3 clear, 2:0 clock.
module etc_timer0_control
    import etc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    input wire etc_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extClk,
    input wire logic extReset,
    output logic irq
);
    function automatic logic [15:0] regIndex(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:IDX_LSB];
    endfunction

    function automatic logic isMapped(input logic [15:0] i);
        return i == SER_TMR_CLK_CTRL_IDX || i == TIMER0_CONTROL_IDX
            || i == PERIPH_CLK_CTRL_IDX || i == IRQ_STATUS_IDX
            || i == IRQ_CLEAR_IDX || i == IRQ_ENABLE_IDX
            || i == COMPARE_A_IDX || i == COMPARE_B_IDX || i == COUNTER_IDX;
    endfunction

    // Pin synchronisers: first stage feeds only the second
    logic [1:0] clkSync_reg;
    logic [1:0] rstSync_reg;
    logic extClkPrev_reg;
    logic extRstPrev_reg;

    etc_ctrl_t ctrl_reg, ctrl_next;
    logic [1:0] prescaleAlt_reg, prescaleAlt_next;
    logic periphHalve_reg, periphHalve_next;
    logic [7:0] cmpA_reg, cmpA_next;
    logic [7:0] cmpB_reg, cmpB_next;
    logic [7:0] count_reg, count_next;
    logic [EV_W-1:0] status_reg, status_next;
    logic [EV_W-1:0] irqEn_reg, irqEn_next;
    logic [PRESCALE_W-1:0] pre_reg, pre_next;
    logic phase_reg, phase_next;
    logic tapPrev_reg, tapPrev_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next, irq_next;

    logic [15:0] idx;
    logic setup, wr, rd;
    logic periphTick, tap, countTick, matchA, matchB, overflow, clearHit;
    logic extRise, extFall, extRstRise;
    logic [EV_W-1:0] events;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkSync_reg <= 2'h0;
            rstSync_reg <= 2'h0;
            extClkPrev_reg <= 1'b0;
            extRstPrev_reg <= 1'b0;
        end else if (clkEn) begin
            clkSync_reg <= {clkSync_reg[0], extClk};
            rstSync_reg <= {rstSync_reg[0], extReset};
            extClkPrev_reg <= clkSync_reg[1];
            extRstPrev_reg <= rstSync_reg[1];
        end
    end

    always_comb begin
        extRise = clkSync_reg[1] & ~extClkPrev_reg;
        extFall = ~clkSync_reg[1] & extClkPrev_reg;
        extRstRise = rstSync_reg[1] & ~extRstPrev_reg;
    end

    // APB decode: zero-wait, answer in the access cycle
    always_comb begin
        idx = regIndex(apbReq.paddr);
        setup = apbReq.psel & ~apbReq.penable;
        wr = apbReq.psel & apbReq.penable & apbReq.pwrite & isMapped(idx) & apbReq.pstrb[0];
        rd = setup & ~apbReq.pwrite;
    end

    // Prescaler and tick selection
    always_comb begin
        phase_next = phase_reg;
        pre_next = pre_reg;
        if (periphHalve_reg) begin
            periphTick = phase_reg;
            phase_next = ~phase_reg;
        end else begin
            periphTick = 1'b1;
            phase_next = 1'b0;
        end
        if (periphTick) begin
            pre_next = pre_reg + 1'b1;
        end
        unique case (ctrl_reg.clkSel)
            CKS_DIV_A: tap = prescaleAlt_reg[PRESCALE_SEL_BIT] ? pre_reg[TAP_DIV2]
                : pre_reg[TAP_DIV8];
            CKS_DIV_B: tap = prescaleAlt_reg[PRESCALE_SEL_BIT] ? pre_reg[TAP_DIV32]
                : pre_reg[TAP_DIV64];
            CKS_DIV_C: tap = prescaleAlt_reg[PRESCALE_SEL_BIT] ? pre_reg[TAP_DIV256]
                : pre_reg[TAP_DIV1024];
            default: tap = 1'b0;
        endcase
        tapPrev_next = tap;
        unique case (ctrl_reg.clkSel)
            CKS_STOP0, CKS_STOP4: countTick = 1'b0;
            CKS_DIV_A, CKS_DIV_B, CKS_DIV_C: countTick = tapPrev_reg & ~tap;
            CKS_EXT_RISE: countTick = extRise;
            CKS_EXT_FALL: countTick = extFall;
            CKS_EXT_BOTH: countTick = extRise | extFall;
        endcase
    end

    // Counter, matches, clear source
    always_comb begin
        matchA = count_reg == cmpA_reg;
        matchB = count_reg == cmpB_reg;
        overflow = countTick & (count_reg == COUNT_MAX);
        unique case (ctrl_reg.clearSel)
            CLR_NONE: clearHit = 1'b0;
            CLR_CMPA: clearHit = countTick & matchA;
            CLR_CMPB: clearHit = countTick & matchB;
            CLR_EXT: clearHit = extRstRise;
        endcase
        if (clearHit) begin
            count_next = 8'h00;
        end else if (countTick) begin
            count_next = count_reg + 1'b1;
        end else begin
            count_next = count_reg;
        end
        if (wr && idx == COUNTER_IDX) begin
            count_next = apbReq.pwdata[7:0];
        end
        events = '0;
        events[EV_OVF] = overflow;
        events[EV_CMPA] = countTick & matchA;
        events[EV_CMPB] = countTick & matchB;
    end

    // Registers, status and interrupt
    always_comb begin
        ctrl_next = ctrl_reg;
        prescaleAlt_next = prescaleAlt_reg;
        periphHalve_next = periphHalve_reg;
        cmpA_next = cmpA_reg;
        cmpB_next = cmpB_reg;
        irqEn_next = irqEn_reg;
        if (wr) begin
            unique case (idx)
                TIMER0_CONTROL_IDX: ctrl_next = apbReq.pwdata[7:0];
                SER_TMR_CLK_CTRL_IDX: prescaleAlt_next = apbReq.pwdata[1:0];
                PERIPH_CLK_CTRL_IDX: periphHalve_next = apbReq.pwdata[PHALVE_BIT];
                COMPARE_A_IDX: cmpA_next = apbReq.pwdata[7:0];
                COMPARE_B_IDX: cmpB_next = apbReq.pwdata[7:0];
                IRQ_ENABLE_IDX: irqEn_next = apbReq.pwdata[EV_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        status_next = status_reg;
        if (wr && idx == IRQ_CLEAR_IDX) begin
            status_next = status_reg & ~apbReq.pwdata[EV_W-1:0];
        end
        status_next = status_next | events;
        irq_next = |(status_next & irqEn_next & {ctrl_next.cmpBIrqEn,
            ctrl_next.cmpAIrqEn, ctrl_next.overflowIrqEn});
        prdata_next = 32'h0;
        if (rd) begin
            unique case (idx)
                TIMER0_CONTROL_IDX: prdata_next[7:0] = ctrl_reg;
                SER_TMR_CLK_CTRL_IDX: prdata_next[1:0] = prescaleAlt_reg;
                PERIPH_CLK_CTRL_IDX: prdata_next[PHALVE_BIT] = periphHalve_reg;
                COMPARE_A_IDX: prdata_next[7:0] = cmpA_reg;
                COMPARE_B_IDX: prdata_next[7:0] = cmpB_reg;
                COUNTER_IDX: prdata_next[7:0] = count_reg;
                IRQ_STATUS_IDX: prdata_next[EV_W-1:0] = status_reg;
                IRQ_ENABLE_IDX: prdata_next[EV_W-1:0] = irqEn_reg;
                default: ;
            endcase
        end
        pready_next = setup;
        pslverr_next = setup & ~isMapped(idx);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            prescaleAlt_reg <= PRESCALE_RESET;
            periphHalve_reg <= 1'b0;
            cmpA_reg <= COUNT_MAX;
            cmpB_reg <= COUNT_MAX;
            count_reg <= 8'h00;
            status_reg <= '0;
            irqEn_reg <= '0;
            pre_reg <= '0;
            phase_reg <= 1'b0;
            tapPrev_reg <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else if (clkEn) begin
            ctrl_reg <= ctrl_next;
            prescaleAlt_reg <= prescaleAlt_next;
            periphHalve_reg <= periphHalve_next;
            cmpA_reg <= cmpA_next;
            cmpB_reg <= cmpB_next;
            count_reg <= count_next;
            status_reg <= status_next;
            irqEn_reg <= irqEn_next;
            pre_reg <= pre_next;
            phase_reg <= phase_next;
            tapPrev_reg <= tapPrev_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            irq <= irq_next;
        end
    end
endmodule

`default_nettype wire

// ==== test/etc_timer0_control_sva.sv ====
// Port checker for the timer control block.
// Bound to the block's top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module etc_timer0_control_sva
    import etc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    input wire etc_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire setup = apbReq.psel && !apbReq.penable && clkEn;
    wire ctl = apbReq.paddr == {TIMER0_CONTROL_IDX, 2'h0};
    wire ctlOff = pready && ctl && apbReq.pwrite && apbReq.pstrb[0] && apbReq.pwdata[7:5] == 3'h0;
    property p_ans; setup |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_pulse; pready && clkEn |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_acc; pready |-> apbReq.psel && apbReq.penable; endproperty
    a_acc: assert property (p_acc) else $error("stray ready");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_ctl; pready && ctl && !apbReq.pwrite |-> !pslverr && prdata[31:8] == 24'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("bad control read");
    property p_rq; $fell(rst) |-> !irq [*4]; endproperty
    a_rq: assert property (p_rq) else $error("irq after reset");
    property p_rr; $fell(rst) |-> !pready && prdata == 32'h0; endproperty
    a_rr: assert property (p_rr) else $error("bus busy after reset");
    property p_off; ctlOff |-> ##[1:3] !irq; endproperty
    a_off: assert property (p_off) else $error("irq not masked");
endmodule
`default_nettype wire

// ==== test/etc_pin_model.sv ====
// External count clock and counter reset pin model.
// Driven by the bench on the system clock; pins idle low.
`timescale 1ns/1ps
`default_nettype none
module etc_pin_model (
    input wire logic clock,
    input wire logic [7:0] clkPulses,
    input wire logic startClk,
    input wire logic resetPulse,
    output logic extClk,
    output logic extReset,
    output logic busy
);
    initial begin
        extClk = 1'b0;
        extReset = 1'b0;
        busy = 1'b0;
    end
    // Four cycles a level so the 2-stage synchroniser sees each edge
    always @(posedge clock) begin
        if (startClk || resetPulse) begin
            busy <= 1'b1;
            extReset <= resetPulse;
            for (int i = 0; i < clkPulses; i++) begin
                repeat (4) @(posedge clock);
                extClk <= 1'b1;
                repeat (4) @(posedge clock);
                extClk <= 1'b0;
            end
            repeat (4) @(posedge clock);
            extReset <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== test/etc_timer0_control_tb.sv ====
// Bench for the timer control block: APB tasks and pin model.
// Waits up to 20 cycles for each APB answer; checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module etc_timer0_control_tb
    import etc_pkg::*;
;
    localparam logic [15:0] CTL = TIMER0_CONTROL_IDX;
    localparam logic [15:0] CNT = COUNTER_IDX;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    etc_apb_req_t req = '0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, extClk, extReset, irq, busy, rerr;
    logic [7:0] clkPulses = 8'h0;
    logic startClk = 1'b0;
    logic resetPulse = 1'b0;
    int nErrors = 0;
    int testsRun = 0;
    int sel[8] = '{1, 2, 3, 1, 2, 3, 1, 4};
    int alt[8] = '{0, 0, 0, 1, 1, 1, 1, 1};
    int hv[8] = '{0, 0, 0, 0, 0, 0, 1, 0};
    int dv[8] = '{8, 64, 1024, 2, 32, 256, 4, 0};
    always #25 clock = ~clock;
    etc_timer0_control dut (.clock(clock), .rst(rst), .clkEn(clkEn), .apbReq(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .extClk(extClk),
        .extReset(extReset), .irq(irq));
    etc_pin_model pins (.clock(clock), .clkPulses(clkPulses), .startClk(startClk),
        .resetPulse(resetPulse), .extClk(extClk), .extReset(extReset), .busy(busy));
    task automatic summarize;
        $display("checks %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
        int n = 0;
        req.paddr <= {idx, 2'h0};
        req.pwrite <= wr;
        req.pwdata <= wd;
        req.psel <= 1'b1;
        @(posedge clock);
        req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // Idle cycle keeps strobes from being driven twice in one step
        @(posedge clock);
        if (n >= 20) begin
            nErrors++;
            summarize();
        end
    endtask
    task automatic halt;
        apb(CTL, 1, 0);
        apb(CNT, 0, 0);
    endtask
    task automatic pulse(input logic [7:0] n, input logic r);
        int t = 0;
        clkPulses <= n;
        startClk <= !r;
        resetPulse <= r;
        @(posedge clock);
        startClk <= 1'b0;
        resetPulse <= 1'b0;
        repeat (2) @(posedge clock);
        for (t = 0; t < 200 && busy === 1'b1; t++) @(posedge clock);
        check("pins idle", busy, 0);
        // A stuck pin model ends the run as a failure
        if (busy === 1'b1) summarize();
        repeat (6) @(posedge clock);
    endtask
    initial begin
        req.pstrb = 4'hf;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(CTL, 0, 0);
        check("ctrl reset", rdata, 32'h0);
        apb(CTL, 1, 32'hffffffa5);
        apb(CTL, 0, 0);
        check("ctrl a5", rdata, 32'ha5);
        apb(CTL, 1, 32'h5a);
        apb(CTL, 0, 0);
        check("ctrl 5a", rdata, 32'h5a);
        apb(16'h0100, 0, 0);
        check("unmapped", {rerr, rdata[30:0]}, 32'h80000000);
        $display("register test done");
        for (int k = 0; k < 8; k++) begin
            halt();
            apb(CNT, 1, 0);
            apb(SER_TMR_CLK_CTRL_IDX, 1, alt[k] << PRESCALE_SEL_BIT);
            apb(PERIPH_CLK_CTRL_IDX, 1, hv[k] << PHALVE_BIT);
            apb(CTL, 1, sel[k]);
            repeat (dv[k] == 0 ? 100 : dv[k] * 10) @(posedge clock);
            halt();
            check("rate", dv[k] == 0 ? rdata == 0 : rdata inside {[9:12]}, 1);
        end
        for (int k = 5; k < 8; k++) begin
            apb(CNT, 1, 0);
            apb(CTL, 1, k);
            pulse(8'd6, 1'b0);
            halt();
            check("ext count", rdata, k == 7 ? 12 : 6);
        end
        $display("count test done");
        apb(COMPARE_A_IDX, 1, 5);
        apb(COMPARE_B_IDX, 1, 7);
        for (int k = 1; k < 3; k++) begin
            apb(CNT, 1, 0);
            apb(CTL, 1, (k << 3) | 1);
            repeat (100) @(posedge clock);
            halt();
            check("match clear", rdata <= 32'(k * 2 + 3), 1);
        end
        apb(CNT, 1, 8'h40);
        apb(CTL, 1, 8'h1b);
        pulse(8'd0, 1'b1);
        halt();
        check("ext clear", rdata < 32'h3, 1);
        $display("clear test done");
        apb(IRQ_ENABLE_IDX, 1, 7);
        apb(CNT, 1, 8'hfc);
        apb(CTL, 1, 8'h21);
        for (int t = 0; t < 60 && irq !== 1'b1; t++) @(posedge clock);
        check("ovf irq", irq, 1);
        if (irq !== 1'b1) summarize();
        apb(CTL, 1, 8'h01);
        repeat (3) @(posedge clock);
        check("ovf masked", irq, 0);
        halt();
        apb(IRQ_STATUS_IDX, 0, 0);
        check("ovf status", rdata[EV_OVF], 1);
        apb(IRQ_CLEAR_IDX, 1, 1 << EV_OVF);
        apb(IRQ_STATUS_IDX, 0, 0);
        check("ovf cleared", rdata[EV_OVF], 0);
        apb(CNT, 1, 0);
        apb(COMPARE_A_IDX, 1, 3);
        apb(CTL, 1, 8'h01);
        repeat (20) @(posedge clock);
        check("cmpa blocked", irq, 0);
        apb(CTL, 1, 8'h41);
        repeat (3) @(posedge clock);
        check("cmpa irq", irq, 1);
        $display("interrupt test done");
        // Clock enable low must freeze the running counter
        apb(CNT, 1, 0);
        apb(CTL, 1, 8'h01);
        clkEn <= 1'b0;
        repeat (40) @(posedge clock);
        clkEn <= 1'b1;
        @(posedge clock);
        halt();
        check("frozen count", rdata < 32'h6, 1);
        // Reset after a halt, with the interrupt masked by the control enables
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check("irq after reset", irq, 0);
        apb(CTL, 0, 0);
        check("ctrl after reset", rdata, 32'h0);
        $display("enable and reset test done");
        summarize();
    end
endmodule
bind etc_timer0_control etc_timer0_control_sva chk (.clock(clock), .rst(rst), .clkEn(clkEn),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
